// ===== hw/dmp_params.svh
// timing counts, mode values and data window offsets of the ddr2 memory port
`ifndef DMP_PARAMS_SVH
`define DMP_PARAMS_SVH
`define DMP_CLK_NS 50
`define DMP_REFI_NS 7800
`define DMP_REFI_CYC (`DMP_REFI_NS / `DMP_CLK_NS)
`define DMP_PWR_NS 200000
`define DMP_PWR_CYC ((`DMP_PWR_NS + `DMP_CLK_NS - 1) / `DMP_CLK_NS)
`define DMP_GAP_CK 2'h1
`define DMP_INIT_LAST 4'hB
`define DMP_MR_RUN 13'h0032
`define DMP_MR_DLLRST 13'h0132
`define DMP_EMR_OCD 13'h0380
`define DMP_A10_ALL 13'h0400
`define DMP_WR_DQS_FIRST 6'h06
`define DMP_WR_DQS_LAST 6'h10
`define DMP_WR_DQ_FIRST 6'h08
`define DMP_WR_DQ_LAST 6'h0F
`define DMP_WR_HI_FIRST 6'h09
`define DMP_WR_HI_LAST 6'h0E
`define DMP_WR_END 6'h11
`define DMP_RD_OPEN 6'h0D
`define DMP_RD_TMO 6'h28
`endif

// ===== hw/dmp_pkg.sv
// types shared by the ddr2 memory port modules
package dmp_pkg;
  typedef enum logic [8:0] {
    ST_PWR = 9'h001, ST_INIT = 9'h002, ST_IDLE = 9'h004, ST_DEC = 9'h008, ST_PRE = 9'h010,
    ST_ACT = 9'h020, ST_RW = 9'h040, ST_XFER = 9'h080, ST_REF = 9'h100
  } dmp_state_e;
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_NOP = 3'h7
  } dmp_cmd_e;
  typedef struct packed {
    dmp_cmd_e cmd;
    logic [1:0] ba;
    logic [12:0] addr;
  } dmp_cmd_s;
endpackage

// ===== hw/dmp_row_if.sv
// open-row lookup signals between controller and row tracker
`timescale 1ns/1ps
interface dmp_row_if #(parameter int BW = 2, parameter int RW = 13);
  logic [BW-1:0] bank;
  logic [RW-1:0] row;
  logic set;
  logic clr_one;
  logic clr_all;
  logic open;
  logic hit;
  modport ctl(output bank, row, set, clr_one, clr_all, input open, hit);
  modport trk(input bank, row, set, clr_one, clr_all, output open, hit);
endinterface

// ===== hw/dmp_row_track.sv
// per-bank open row memory with registered lookup
`timescale 1ns/1ps
module dmp_row_track #(
  parameter int BW = 2,
  parameter int RW = 13
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  dmp_row_if.trk rt
);
  localparam int NB = 1 << BW;
  logic [RW-1:0] row_mem [NB];
  logic [NB-1:0] open_q;

  // one row slot and open flag per bank
  for (genvar b = 0; b < NB; b++) begin : g_bank
    always_ff @(posedge i_ref_clk) begin
      if (rt.set && rt.bank == BW'(b)) begin
        row_mem[b] <= rt.row;
      end
    end
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || rt.clr_all) begin
        open_q[b] <= 1'b0;
      end else if (rt.set && rt.bank == BW'(b)) begin
        open_q[b] <= 1'b1;
      end else if (rt.clr_one && rt.bank == BW'(b)) begin
        open_q[b] <= 1'b0;
      end
    end
  end

  // lookup result comes out of registers
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rt.open <= 1'b0;
      rt.hit <= 1'b0;
    end else begin
      rt.open <= open_q[rt.bank];
      rt.hit <= row_mem[rt.bank] == rt.row;
    end
  end
endmodule // dmp_row_track

// ===== hw/dmp_ddr2_port.sv
// ddr2 memory port: init, refresh, row handling and burst-4 data movement
`timescale 1ns/1ps
`include "dmp_params.svh"

// Notes on behaviour
// - drive four x16 ddr2 devices as one 64-bit memory with generated clock
// - strobe driven by memory on reads, by this port on writes
// - read strobe edges align with data; write strobe edges sit mid-eye
// - commands presented so memory samples them at the rising ck crossing
// - write data on both strobe edges; read data captured on both edges
// - every access is a burst of programmed length and order
// - access to a closed bank or another row opens with activate; a row hit goes straight to read or write
// - activate carries bank and row address
// - read or write carries bank and starting column
// - works with ddr2 parts of at least the rated speed, x16 each
module dmp_ddr2_port #(
  parameter int DQ_W = 64,
  parameter int NS = 4,
  parameter int BW = 2,
  parameter int RW = 13,
  parameter int CW = 10,
  parameter int PWR_CYC = `DMP_PWR_CYC,
  parameter int REFI_CYC = `DMP_REFI_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [BW+RW+CW-1:0] i_addr,
  input wire logic [4*DQ_W-1:0] i_wdata,
  output logic o_ack,
  output logic o_done,
  output logic o_rd_err,
  output logic [4*DQ_W-1:0] o_rdata,
  output logic o_init_done,
  output logic o_ck,
  output logic o_ck_n,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [BW-1:0] o_ba,
  output logic [12:0] o_addr,
  output logic [DQ_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic [DQ_W-1:0] i_dq,
  output logic [NS-1:0] o_dqs,
  output logic [NS-1:0] o_dqs_n,
  output logic o_dqs_oe,
  input wire logic [NS-1:0] i_dqs
);
  import dmp_pkg::*;

  dmp_state_e st_q, st_d;
  dmp_cmd_s cmd_d;
  logic [1:0] ph_q;
  logic [1:0] gap_q, gap_d;
  logic [3:0] step_q, step_d;
  logic [15:0] pwr_q;
  logic [15:0] ref_cnt_q;
  logic ref_due_q;
  logic [5:0] dcnt_q;
  logic req_we_q;
  logic [BW-1:0] req_ba_q;
  logic [RW-1:0] req_row_q;
  logic [CW-1:0] req_col_q;
  logic [4*DQ_W-1:0] wdata_q;
  logic [DQ_W-1:0] dq_s1, dq_s2;
  logic dqs_s1, dqs_s2, dqs_s3;
  logic [1:0] rbeat_q;
  logic rd_fin_q;
  logic slot, fire, rw_fire, take, xfer_end, rd_edge, rd_arm;
  logic [5:0] hi_ofs;

  dmp_row_if #(.BW(BW), .RW(RW)) rt();

  dmp_row_track #(.BW(BW), .RW(RW)) u_track (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .rt(rt)
  );

  // init sequence: precharge, extended modes, dll reset, refreshes, mode, ocd
  function automatic dmp_cmd_s init_cmd(input logic [3:0] s);
    dmp_cmd_s c;
    c = '{CMD_NOP, 2'h0, 13'h0000};
    case (s)
      4'h1, 4'h6: c = '{CMD_PRE, 2'h0, `DMP_A10_ALL};
      4'h2: c = '{CMD_MRS, 2'h2, 13'h0000};
      4'h3: c = '{CMD_MRS, 2'h3, 13'h0000};
      4'h4, 4'hB: c = '{CMD_MRS, 2'h1, 13'h0000};
      4'h5: c = '{CMD_MRS, 2'h0, `DMP_MR_DLLRST};
      4'h7, 4'h8: c = '{CMD_REF, 2'h0, 13'h0000};
      4'h9: c = '{CMD_MRS, 2'h0, `DMP_MR_RUN};
      4'hA: c = '{CMD_MRS, 2'h1, `DMP_EMR_OCD};
      default: c = '{CMD_NOP, 2'h0, 13'h0000};
    endcase
    return c;
  endfunction

  // command slots: one per memory clock period of four ref cycles
  assign slot = ph_q == 2'h3;
  assign fire = slot && gap_q == 2'h0;
  assign rw_fire = fire && st_q == ST_RW;
  assign take = fire && st_q == ST_IDLE && !ref_due_q && i_req;
  assign rd_edge = dqs_s2 ^ dqs_s3;
  assign rd_arm = st_q == ST_XFER && !req_we_q && dcnt_q >= `DMP_RD_OPEN && !rd_fin_q;
  assign xfer_end = req_we_q ? dcnt_q >= `DMP_WR_END : rd_fin_q;
  assign hi_ofs = dcnt_q - `DMP_WR_HI_FIRST;

  // tracker hooks follow the latched request
  assign rt.bank = req_ba_q;
  assign rt.row = req_row_q;
  assign rt.set = fire && st_q == ST_ACT;
  assign rt.clr_one = fire && st_q == ST_PRE;
  assign rt.clr_all = fire && st_q == ST_IDLE && ref_due_q;

  // memory clock at a quarter of ref clock; high in phases 2 and 3
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ph_q <= 2'h0;
      o_ck <= 1'b0;
      o_ck_n <= 1'b1;
    end else begin
      ph_q <= ph_q + 2'h1;
      o_ck <= ph_q == 2'h1 || ph_q == 2'h2;
      o_ck_n <= !(ph_q == 2'h1 || ph_q == 2'h2);
    end
  end

  // next state and command choice
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    gap_d = gap_q;
    cmd_d = '{CMD_NOP, 2'h0, 13'h0000};
    if (gap_q != 2'h0) begin
      gap_d = gap_q - 2'h1;
    end else begin
      case (st_q)
        ST_PWR: if (pwr_q == 16'h0000) st_d = ST_INIT;
        ST_INIT: begin
          cmd_d = init_cmd(step_q);
          gap_d = `DMP_GAP_CK;
          step_d = step_q + 4'h1;
          if (step_q == `DMP_INIT_LAST) st_d = ST_IDLE;
        end
        ST_IDLE: begin
          if (ref_due_q) begin
            cmd_d = '{CMD_PRE, 2'h0, `DMP_A10_ALL};
            gap_d = `DMP_GAP_CK;
            st_d = ST_REF;
          end else if (i_req) begin
            st_d = ST_DEC;
          end
        end
        ST_DEC: begin
          if (!rt.open) st_d = ST_ACT;
          else if (rt.hit) st_d = ST_RW;
          else st_d = ST_PRE;
        end
        ST_PRE: begin
          cmd_d = '{CMD_PRE, req_ba_q, 13'h0000};
          gap_d = `DMP_GAP_CK;
          st_d = ST_ACT;
        end
        ST_ACT: begin
          cmd_d = '{CMD_ACT, req_ba_q, req_row_q};
          gap_d = `DMP_GAP_CK;
          st_d = ST_RW;
        end
        ST_RW: begin
          cmd_d.cmd = req_we_q ? CMD_WR : CMD_RD;
          cmd_d.ba = req_ba_q;
          cmd_d.addr = {3'h0, req_col_q};
          st_d = ST_XFER;
        end
        ST_XFER: if (xfer_end) st_d = ST_IDLE;
        ST_REF: begin
          cmd_d = '{CMD_REF, 2'h0, 13'h0000};
          gap_d = `DMP_GAP_CK;
          st_d = ST_IDLE;
        end
        default: st_d = ST_PWR;
      endcase
    end
  end

  // state and command pins change only at slot, ck low half
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_PWR;
      step_q <= 4'h0;
      gap_q <= 2'h0;
      {o_ras_n, o_cas_n, o_we_n} <= CMD_NOP;
      o_ba <= '0;
      o_addr <= 13'h0000;
    end else if (slot) begin
      st_q <= st_d;
      step_q <= step_d;
      gap_q <= gap_d;
      {o_ras_n, o_cas_n, o_we_n} <= cmd_d.cmd;
      o_ba <= cmd_d.ba;
      o_addr <= cmd_d.addr;
    end
  end

  // chip select, clock enable and init status
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_cs_n <= 1'b1;
      o_cke <= 1'b0;
      o_init_done <= 1'b0;
    end else begin
      o_cs_n <= st_q == ST_PWR;
      if (st_q == ST_INIT) o_cke <= 1'b1;
      if (st_q == ST_IDLE) o_init_done <= 1'b1;
    end
  end

  // power-up wait and refresh interval timers; request wins over clear
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pwr_q <= 16'(PWR_CYC);
      ref_cnt_q <= 16'(REFI_CYC - 1);
      ref_due_q <= 1'b0;
    end else begin
      if (pwr_q != 16'h0000) pwr_q <= pwr_q - 16'h0001;
      if (o_init_done) begin
        ref_cnt_q <= ref_cnt_q == 16'h0000 ? 16'(REFI_CYC - 1) : ref_cnt_q - 16'h0001;
      end
      if (o_init_done && ref_cnt_q == 16'h0000) ref_due_q <= 1'b1;
      else if (fire && st_q == ST_REF) ref_due_q <= 1'b0;
    end
  end

  // request latch and acknowledge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_ack <= 1'b0;
      req_we_q <= 1'b0;
      req_ba_q <= '0;
      req_row_q <= '0;
      req_col_q <= '0;
      wdata_q <= '0;
    end else begin
      o_ack <= take;
      if (take) begin
        req_we_q <= i_we;
        {req_ba_q, req_row_q, req_col_q} <= i_addr;
        wdata_q <= i_wdata;
      end
    end
  end

  // ref cycles since the read or write command went out
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) dcnt_q <= 6'h3F;
    else if (rw_fire) dcnt_q <= 6'h00;
    else if (dcnt_q != 6'h3F) dcnt_q <= dcnt_q + 6'h01;
  end

  // write burst: preamble, four beats, strobe edges centred in each beat
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_dq_oe <= 1'b0;
      o_dqs_oe <= 1'b0;
      o_dq <= '0;
      o_dqs <= '0;
      o_dqs_n <= '1;
    end else begin
      o_dq_oe <= st_q == ST_XFER && req_we_q && dcnt_q >= `DMP_WR_DQ_FIRST
        && dcnt_q <= `DMP_WR_DQ_LAST;
      o_dqs_oe <= st_q == ST_XFER && req_we_q && dcnt_q >= `DMP_WR_DQS_FIRST
        && dcnt_q <= `DMP_WR_DQS_LAST;
      o_dq <= wdata_q[dcnt_q[2:1]*DQ_W +: DQ_W];
      o_dqs <= {NS{dcnt_q >= `DMP_WR_HI_FIRST && dcnt_q <= `DMP_WR_HI_LAST && !hi_ofs[1]}};
      o_dqs_n <= ~{NS{dcnt_q >= `DMP_WR_HI_FIRST && dcnt_q <= `DMP_WR_HI_LAST && !hi_ofs[1]}};
    end
  end

  // pin synchronisers for read data and strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_s3 <= 1'b0;
    end else begin
      dq_s1 <= i_dq;
      dq_s2 <= dq_s1;
      dqs_s1 <= i_dqs[0];
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
    end
  end

  // read burst: a beat on every strobe edge, four beats per burst
  for (genvar k = 0; k < 4; k++) begin : g_rbeat
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) o_rdata[k*DQ_W +: DQ_W] <= '0;
      else if (rd_arm && rd_edge && rbeat_q == 2'(k)) o_rdata[k*DQ_W +: DQ_W] <= dq_s2;
    end
  end

  // burst completion, timeout and done pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rbeat_q <= 2'h0;
      rd_fin_q <= 1'b0;
      o_done <= 1'b0;
      o_rd_err <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_rd_err <= 1'b0;
      if (rw_fire) begin
        rbeat_q <= 2'h0;
        rd_fin_q <= 1'b0;
      end else if (rd_arm && rd_edge) begin
        rbeat_q <= rbeat_q + 2'h1;
        if (rbeat_q == 2'h3) begin
          rd_fin_q <= 1'b1;
          o_done <= 1'b1;
        end
      end else if (rd_arm && dcnt_q == `DMP_RD_TMO) begin
        rd_fin_q <= 1'b1;
        o_rd_err <= 1'b1;
      end
      if (req_we_q && st_q == ST_XFER && dcnt_q == `DMP_WR_END) o_done <= 1'b1;
    end
  end

  // checks on the pin sequence
  logic iss;
  logic [(1<<BW)-1:0] bk_open_q;
  logic [15:0] ref_age_q;
  assign iss = ph_q == 2'h0 && {o_ras_n, o_cas_n, o_we_n} != CMD_NOP;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) bk_open_q <= '0;
    else if (iss && {o_ras_n, o_cas_n, o_we_n} == CMD_ACT) bk_open_q[o_ba] <= 1'b1;
    else if (iss && {o_ras_n, o_cas_n, o_we_n} == CMD_PRE) begin
      if (o_addr[10]) bk_open_q <= '0;
      else bk_open_q[o_ba] <= 1'b0;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || !o_init_done) ref_age_q <= 16'h0000;
    else if (iss && {o_ras_n, o_cas_n, o_we_n} == CMD_REF) ref_age_q <= 16'h0000;
    else ref_age_q <= ref_age_q + 16'h0001;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr_iss;
    iss && {o_ras_n, o_cas_n, o_we_n} == CMD_WR;
  endsequence
  sequence s_wr_beats;
    o_dq_oe [*8] ##1 !o_dq_oe;
  endsequence

  chk_act_closed_bank: assert property (iss && {o_ras_n, o_cas_n, o_we_n} == CMD_ACT
    |-> !bk_open_q[o_ba]) else $error("activate to a bank with an open row");
  chk_rw_after_act: assert property (iss && o_ras_n && !o_cas_n
    |-> bk_open_q[o_ba]) else $error("read or write without activate");
  chk_act_row_addr: assert property (iss && {o_ras_n, o_cas_n, o_we_n} == CMD_ACT
    |-> o_addr == req_row_q && o_ba == req_ba_q) else $error("activate address wrong");
  chk_rw_col_addr: assert property (iss && o_ras_n && !o_cas_n
    |-> o_addr[CW-1:0] == req_col_q && !o_addr[10] && o_ba == req_ba_q)
    else $error("column address wrong");
  chk_cmd_ck_low: assert property ($changed(o_ras_n) || $changed(o_addr)
    |-> !o_ck && $past(ph_q) == 2'h3) else $error("command changed off slot");
  chk_wr_dq_window: assert property (s_wr_iss |-> ##9 s_wr_beats)
    else $error("write data window misplaced");
  chk_wdqs_mid_eye: assert property (o_dq_oe && $changed(o_dqs) |-> $stable(o_dq))
    else $error("write strobe moved with data");
  chk_rd_burst_end: assert property (iss && {o_ras_n, o_cas_n, o_we_n} == CMD_RD
    |-> ##[14:44] (o_done || o_rd_err)) else $error("read burst never ended");
  chk_init_before_use: assert property (iss && !o_cas_n && o_ras_n |-> o_init_done)
    else $error("access before init finished");
  chk_ref_interval: assert property (ref_age_q <= 16'(REFI_CYC + 200))
    else $error("refresh overdue");
endmodule // dmp_ddr2_port

// ===== verif/dmp_mem_model.sv
// behavioural ddr2 partner: four x16 parts seen as one 64-bit memory
`timescale 1ns/1ps
module dmp_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_short,
  input wire logic i_ck,
  input wire logic [3:0] i_cmd,
  input wire logic [1:0] i_ba,
  input wire logic [12:0] i_addr,
  input wire logic [63:0] i_dq,
  input wire logic [3:0] i_dqs,
  input wire logic i_dqs_oe,
  output logic [63:0] o_dq,
  output logic [3:0] o_dqs,
  output int o_viol,
  output int o_refs,
  output int o_mrs
);
  logic [63:0] store [logic [24:0]];
  logic [12:0] row_q [4];
  logic [3:0] open_q;
  logic ck_p, dqs_p, oe_p, rd_on;
  logic [63:0] dq_p;
  logic [24:0] base;
  int rcnt, wbeat, n;
  // sequential burst-4 order wraps inside an aligned group
  function automatic logic [24:0] key(input logic [24:0] b, input int k);
    return {b[24:2], b[1:0] + 2'(k)};
  endfunction
  // commands taken at each rising ck crossing, data moved on strobe edges
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      open_q = 4'h0;
      rd_on = 1'b0;
      wbeat = 4;
      o_dq <= 64'h0;
      o_dqs <= 4'h0;
    end else begin
      if (i_ck && !ck_p && !i_cmd[3]) begin
        case (i_cmd[2:0])
          3'b000: o_mrs++;
          3'b001: begin
            if (open_q !== 4'h0) o_viol++;
            o_refs++;
          end
          3'b010: open_q = i_addr[10] ? 4'h0 : open_q & ~(4'h1 << i_ba);
          3'b011: begin
            if (open_q[i_ba] || o_mrs < 4) o_viol++;
            open_q[i_ba] = 1'b1;
            row_q[i_ba] = i_addr;
          end
          3'b100, 3'b101: begin
            if (!open_q[i_ba] || i_addr[10]) o_viol++;
            base = {i_ba, row_q[i_ba], i_addr[9:0]};
            wbeat = 0;
            rd_on = i_cmd[0];
            rcnt = 0;
          end
          default: ;
        endcase
      end
      // write beat on each strobe edge, data must stand still across it
      if (i_dqs_oe && oe_p && i_dqs[0] !== dqs_p && wbeat < 4) begin
        if (i_dq !== dq_p) o_viol++;
        store[key(base, wbeat)] = i_dq;
        wbeat++;
      end
      // read: preamble, edge-aligned beats, optional strobe loss, release
      if (rd_on) begin
        rcnt++;
        n = (rcnt - 12) / 2;
        if (rcnt < 8) begin
          o_dq <= ~o_dq;
          o_dqs <= ~o_dqs;
        end else if (rcnt < 12) begin
          o_dq <= ~o_dq;
          o_dqs <= 4'h0;
        end else if (rcnt % 2 == 0 && n < (i_short ? 2 : 4)) begin
          o_dqs <= {4{~n[0]}};
          o_dq <= store.exists(key(base, n)) ? store[key(base, n)] : 64'h0;
        end
        if (rcnt >= (i_short ? 46 : 20)) rd_on = 1'b0;
      end else begin
        // released lines show a pattern that changes every cycle
        o_dq <= ~o_dq;
        o_dqs <= ~o_dqs;
      end
    end
    ck_p = i_ck;
    dqs_p = i_dqs[0];
    oe_p = i_dqs_oe;
    dq_p = i_dq;
  end
endmodule // dmp_mem_model

// ===== verif/dmp_ddr2_port_tb.sv
// self-checking bench for the ddr2 memory port with a partner memory
`timescale 1ns/1ps
module dmp_ddr2_port_tb;
  localparam int REFI = 200;
  logic clk = 1'b0, rst = 1'b1, i_req = 1'b0, i_we = 1'b0, short_q = 1'b0;
  logic [24:0] i_addr = 25'h0;
  logic [255:0] i_wdata = 256'h0;
  logic o_ack, o_done, o_rd_err, o_init_done, o_ck, o_ck_n, o_cke, o_cs_n;
  logic o_ras_n, o_cas_n, o_we_n, o_dq_oe, o_dqs_oe;
  logic [255:0] o_rdata;
  logic [1:0] o_ba;
  logic [12:0] o_addr;
  logic [63:0] o_dq, m_dq, dq_w;
  logic [3:0] o_dqs, o_dqs_n, m_dqs, dqs_w;
  logic [63:0] sb [logic [24:0]];
  logic [24:0] wq [$];
  int n_errors = 0, tests_run = 0, refs0;
  // wire level from whichever side drives
  assign dq_w = o_dq_oe ? o_dq : m_dq;
  assign dqs_w = o_dqs_oe ? o_dqs : m_dqs;
  always #25 clk = ~clk;
  // select, clock enable and differential pairs once init is done
  always @(negedge clk) begin
    if (!rst && o_init_done === 1'b1) begin
      check({o_cs_n, o_cke, o_ck_n, o_dqs_n}, {1'b0, 1'b1, ~o_ck, ~o_dqs});
    end
  end
  dmp_ddr2_port #(.PWR_CYC(20), .REFI_CYC(REFI)) dut (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack),
    .o_done(o_done), .o_rd_err(o_rd_err), .o_rdata(o_rdata), .o_init_done(o_init_done),
    .o_ck(o_ck), .o_ck_n(o_ck_n), .o_cke(o_cke), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n),
    .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba), .o_addr(o_addr), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .i_dq(dq_w), .o_dqs(o_dqs), .o_dqs_n(o_dqs_n), .o_dqs_oe(o_dqs_oe),
    .i_dqs(dqs_w));
  dmp_mem_model mdl (.i_ref_clk(clk), .i_sys_rst(rst), .i_short(short_q), .i_ck(o_ck),
    .i_cmd({o_cs_n, o_ras_n, o_cas_n, o_we_n}), .i_ba(o_ba), .i_addr(o_addr), .i_dq(dq_w),
    .i_dqs(dqs_w), .i_dqs_oe(o_dqs_oe), .o_dq(m_dq), .o_dqs(m_dqs), .o_viol(), .o_refs(),
    .o_mrs());
  // one comparison, counted
  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=0x%h exp=0x%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [24:0] key(input logic [24:0] a, input int k);
    return {a[24:2], a[1:0] + 2'(k)};
  endfunction
  function automatic logic [255:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
  endfunction
  // request held until ack, then wait for done or read error
  task automatic access(input logic we, input logic [24:0] a, output logic err);
    int n;
    @(posedge clk);
    i_req <= 1'b1;
    i_we <= we;
    i_addr <= a;
    i_wdata <= rnd();
    for (n = 0; n < 600; n++) begin
      @(negedge clk);
      if (o_ack === 1'b1) break;
    end
    @(posedge clk);
    i_req <= 1'b0;
    for (n = n; n < 800; n++) begin
      @(negedge clk);
      if (o_done === 1'b1 || o_rd_err === 1'b1) break;
    end
    if (n >= 800) check(n, 0);
    err = (o_rd_err === 1'b1);
  endtask
  task automatic wr(input logic [24:0] a);
    logic e;
    access(1'b1, a, e);
    for (int k = 0; k < 4; k++) begin
      sb[key(a, k)] = i_wdata[64*k +: 64];
      check(mdl.store[key(a, k)], i_wdata[64*k +: 64]);
    end
    wq.push_back(a);
  endtask
  task automatic rd(input logic [24:0] a, input logic sh);
    logic e;
    logic [255:0] x;
    short_q <= sh;
    access(1'b0, a, e);
    for (int k = 0; k < 4; k++) x[64*k +: 64] = sb[key(a, k)];
    check(e, sh);
    if (!sh) check(o_rdata, x);
    short_q <= 1'b0;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(32'h6C51));
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({o_cs_n, o_cke, o_ras_n, o_cas_n, o_we_n, o_dq_oe, o_dqs_oe}, 7'h5C);
    @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 3000 && o_init_done !== 1'b1; n++) @(negedge clk);
    check(o_init_done, 1'b1);
    check(mdl.o_mrs >= 4, 1'b1);
    $display("test init done");
    // hit, miss in the same bank, far corner of bank 3
    wr(25'h0001400);
    wr(25'h0001408);
    wr(25'h0002404);
    wr({2'h3, 13'h1FFF, 10'h3FC});
    wr(25'h0801400);
    $display("test writes done");
    rd(25'h0001408, 1'b0);
    rd(25'h0001401, 1'b0);
    rd(25'h0002406, 1'b0);
    rd({2'h3, 13'h1FFF, 10'h3FF}, 1'b0);
    rd(25'h0801400, 1'b0);
    $display("test reads done");
    refs0 = mdl.o_refs;
    repeat (3 * REFI) @(posedge clk);
    check(mdl.o_refs >= refs0 + 2, 1'b1);
    rd(25'h0001400, 1'b0);
    $display("test refresh done");
    rd(25'h0002404, 1'b1);
    rd(25'h0002405, 1'b0);
    $display("test strobe loss done");
    for (int i = 0; i < 12; i++) wr({2'($urandom), 13'($urandom % 4), 8'($urandom), 2'h0});
    wq.shuffle();
    foreach (wq[i]) rd(wq[i] + 25'($urandom % 4), 1'b0);
    $display("test random done");
    check(mdl.o_viol, 0);
    final_report();
  end
endmodule // dmp_ddr2_port_tb
